/* File: rtl/evt16_counter.sv */
// 16-bit event counter with capture, two comparators and AXI4-Lite registers
// Functional notes
// - 16-bit counter steps once per selected input pulse, cleared only by clear logic.
// - Counter overflow sets a sticky flag software can test.
// - Capture copies counter on pin fall (tick sources) or square fall (pin sources).
// - Source select: tick, tick while pin high, pin fall, pin fall while square high.
// - Pin sampled each sample period; level accepted after two equal samples.
// - Two independent 16-bit compare registers loaded by software.
// - Comparator flags match A and match B on counter equality.
// - Compare value zero matches once every 65536 counts; in clear mode 11, compare A at zero matches on each clear.
// - Writing a compare register suppresses that comparator's match.
// - Clear mode: hold cleared, free run, clear on edge, clear on B match.
// - Edge clear uses pin fall if source bit 1 is 0, else square fall.
// - Clear mode 11 clears counter at compare B value, then keeps counting.
// - On a shared edge, capture completes before the counter is cleared.
// - Interrupt flags set on match A, match B and the selected falling edge.
// - Clear mode 00 holds counter at zero; other modes count and restart.
// - Reset and hardware stop force the mode register to zero.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module evt16_counter
	import evt16_pkg::*;
#(
	parameter int SAMPLE_CYC = EVT16_SAMPLE_CYC,
	parameter int TICK_RATIO = EVT16_TICK_RATIO
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// External pins and stop request
	input wire logic count_pin,
	input wire logic square_out,
	input wire logic hw_stop,
	// Event outputs
	output logic match_a,
	output logic match_b,
	output logic irq_match_a,
	output logic irq_match_b,
	output logic irq_edge,
	output logic overflow_flag,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] sdiv;
		logic [7:0] tdiv;
		logic [3:0] mode;
		logic [15:0] cnt;
		logic [15:0] cap;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic sup_a;
		logic sup_b;
		logic [3:0] status;
		logic match_a;
		logic match_b;
		logic irq_a;
		logic irq_b;
		logic irq_e;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} evt16_state_t;

	evt16_state_t st_r;
	evt16_state_t st_nxt;
	logic sample_tick;
	evt16_pin_t cp_f;
	evt16_pin_t sq_f;

	assign sample_tick = (st_r.sdiv == 8'(SAMPLE_CYC - 1));

	// ==========================================================
	// Pin filters
	evt16_pin_filter u_cp_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.sample_tick(sample_tick),
		.pin_in(count_pin),
		.pin_out(cp_f)
	);

	evt16_pin_filter u_sq_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.sample_tick(sample_tick),
		.pin_in(square_out),
		.pin_out(sq_f)
	);

	// Merge two low byte lanes into a 16-bit value
	function automatic logic [15:0] evt16_merge16(input logic [15:0] old_v,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] v;
		v = old_v;
		if (strb[0]) begin
			v[7:0] = data[7:0];
		end
		if (strb[1]) begin
			v[15:8] = data[15:8];
		end
		return v;
	endfunction : evt16_merge16

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic [1:0] src;
		logic [1:0] clr;
		logic tick12;
		logic step;
		logic edge_ev;
		logic clr_edge;
		logic [15:0] newv;
		logic wrap;
		logic do_wr;
		logic [3:0] w1c;
		logic set_a;
		logic set_b;
		src = st_r.mode[EVT16_SRC_LSB +: 2];
		clr = st_r.mode[EVT16_CLR_LSB +: 2];
		tick12 = 1'b0;
		step = 1'b0;
		edge_ev = 1'b0;
		clr_edge = 1'b0;
		newv = st_r.cnt;
		wrap = 1'b0;
		do_wr = 1'b0;
		w1c = 4'h0;
		set_a = 1'b0;
		set_b = 1'b0;
		st_nxt = st_r;

		// Dividers: sample tick and slower counting tick
		st_nxt.sdiv = sample_tick ? 8'h00 : st_r.sdiv + 8'h01;
		if (sample_tick) begin
			if (st_r.tdiv == 8'(TICK_RATIO - 1)) begin
				st_nxt.tdiv = 8'h00;
				tick12 = 1'b1;
			end else begin
				st_nxt.tdiv = st_r.tdiv + 8'h01;
			end
		end

		// Input selection
		case (src)
			EVT16_SRC_TICK: step = tick12;
			EVT16_SRC_TICK_GATED: step = tick12 && cp_f.level;
			EVT16_SRC_PIN: step = cp_f.fall;
			EVT16_SRC_PIN_GATED: step = cp_f.fall && sq_f.level;
			default: step = 1'b0;
		endcase
		edge_ev = src[1] ? sq_f.fall : cp_f.fall;

		// Capture on the selected edge, using the counter before any clear
		if (edge_ev) begin
			st_nxt.cap = st_r.cnt;
		end

		// Counting and clearing
		case (clr)
			EVT16_CLR_HOLD: newv = EVT16_CNT_RST;
			EVT16_CLR_FREE: begin
				if (step) begin
					newv = st_r.cnt + 16'h0001;
					wrap = (st_r.cnt == EVT16_CNT_MAX);
				end
			end
			EVT16_CLR_EDGE: begin
				clr_edge = edge_ev;
				if (edge_ev) begin
					newv = EVT16_CNT_RST;
				end else if (step) begin
					newv = st_r.cnt + 16'h0001;
					wrap = (st_r.cnt == EVT16_CNT_MAX);
				end
			end
			EVT16_CLR_MATCH_B: begin
				if (step && st_r.cmp_b != EVT16_CNT_RST && st_r.cnt == st_r.cmp_b) begin
					newv = EVT16_CNT_RST;
				end else if (step) begin
					newv = st_r.cnt + 16'h0001;
					wrap = (st_r.cnt == EVT16_CNT_MAX);
				end
			end
			default: newv = EVT16_CNT_RST;
		endcase
		st_nxt.cnt = newv;

		// Comparators fire when a count step lands on the compare value
		st_nxt.match_a = 1'b0;
		st_nxt.match_b = 1'b0;
		if (step && !clr_edge && clr != EVT16_CLR_HOLD) begin
			st_nxt.match_a = !st_r.sup_a && (newv == st_r.cmp_a);
			st_nxt.match_b = !st_r.sup_b && (newv == st_r.cmp_b);
			st_nxt.sup_a = 1'b0;
			st_nxt.sup_b = 1'b0;
		end
		st_nxt.irq_a = st_nxt.match_a;
		st_nxt.irq_b = st_nxt.match_b;
		st_nxt.irq_e = edge_ev;

		// AXI write channels taken independently
		st_nxt.awready = !st_r.aw_got && !st_r.bvalid;
		st_nxt.wready = !st_r.w_got && !st_r.bvalid;
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
			st_nxt.awready = 1'b0;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
			st_nxt.wready = 1'b0;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end

		// Register write once both halves are held
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			do_wr = 1'b1;
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = EVT16_RESP_OKAY;
		end
		if (do_wr) begin
			case (st_r.awaddr)
				EVT16_OFS_MODE: begin
					if (st_r.wstrb[0]) begin
						st_nxt.mode = st_r.wdata[3:0];
					end
				end
				EVT16_OFS_CMP_A: begin
					st_nxt.cmp_a = evt16_merge16(st_r.cmp_a, st_r.wdata, st_r.wstrb);
					st_nxt.sup_a = 1'b1;
				end
				EVT16_OFS_CMP_B: begin
					st_nxt.cmp_b = evt16_merge16(st_r.cmp_b, st_r.wdata, st_r.wstrb);
					st_nxt.sup_b = 1'b1;
				end
				EVT16_OFS_STATUS: begin
					if (st_r.wstrb[0]) begin
						w1c = st_r.wdata[3:0];
					end
				end
				EVT16_OFS_COUNT, EVT16_OFS_CAPTURE: st_nxt.bresp = EVT16_RESP_OKAY;
				default: st_nxt.bresp = EVT16_RESP_SLVERR;
			endcase
		end

		// Write to a compare register also kills a match in the same cycle
		if (do_wr && st_r.awaddr == EVT16_OFS_CMP_A) begin
			st_nxt.match_a = 1'b0;
			st_nxt.irq_a = 1'b0;
		end
		if (do_wr && st_r.awaddr == EVT16_OFS_CMP_B) begin
			st_nxt.match_b = 1'b0;
			st_nxt.irq_b = 1'b0;
		end

		// Sticky status: clear by writing one, new event wins
		set_a = st_nxt.irq_a;
		set_b = st_nxt.irq_b;
		st_nxt.status = st_r.status & ~w1c;
		st_nxt.status[EVT16_ST_OVF] = st_nxt.status[EVT16_ST_OVF] | wrap;
		st_nxt.status[EVT16_ST_MATCH_A] = st_nxt.status[EVT16_ST_MATCH_A] | set_a;
		st_nxt.status[EVT16_ST_MATCH_B] = st_nxt.status[EVT16_ST_MATCH_B] | set_b;
		st_nxt.status[EVT16_ST_EDGE] = st_nxt.status[EVT16_ST_EDGE] | edge_ev;

		// AXI read channel
		st_nxt.arready = !st_r.rvalid && !st_nxt.rvalid;
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
			st_nxt.arready = 1'b1;
		end
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = EVT16_RESP_OKAY;
			case (s_axi_araddr)
				EVT16_OFS_MODE: st_nxt.rdata = {28'h000_0000, st_r.mode};
				EVT16_OFS_COUNT: st_nxt.rdata = {16'h0000, st_r.cnt};
				EVT16_OFS_CAPTURE: st_nxt.rdata = {16'h0000, st_r.cap};
				EVT16_OFS_STATUS: st_nxt.rdata = {28'h000_0000, st_r.status};
				EVT16_OFS_CMP_A, EVT16_OFS_CMP_B: st_nxt.rdata = 32'h0000_0000;
				default: begin
					st_nxt.rdata = 32'h0000_0000;
					st_nxt.rresp = EVT16_RESP_SLVERR;
				end
			endcase
		end

		// Hardware stop clears the mode register
		if (hw_stop) begin
			st_nxt.mode = EVT16_MODE_RST;
		end
	end

	// State register, reset forces mode to zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs straight from flip-flops
	assign match_a = st_r.match_a;
	assign match_b = st_r.match_b;
	assign irq_match_a = st_r.irq_a;
	assign irq_match_b = st_r.irq_b;
	assign irq_edge = st_r.irq_e;
	assign overflow_flag = st_r.status[EVT16_ST_OVF];
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign s_axi_rvalid = st_r.rvalid;

endmodule : evt16_counter

`default_nettype wire

/* File: rtl/evt16_pin_filter.sv */
// Sampled noise filter with falling-edge detector for one pin
`timescale 1ns/1ns
`default_nettype none

module evt16_pin_filter
	import evt16_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sample strobe and raw pin
	input wire logic sample_tick,
	input wire logic pin_in,
	// Filtered result
	output evt16_pin_t pin_out
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [EVT16_ACCEPT_SAMPLES-1:0] hist;
		logic level;
		logic fall;
	} evt16_filt_t;

	evt16_filt_t st_r;
	evt16_filt_t st_nxt;

	// Accept a level after it holds for the full sample history
	always_comb begin
		st_nxt = st_r;
		st_nxt.fall = 1'b0;
		if (sample_tick) begin
			st_nxt.hist = {st_r.hist[EVT16_ACCEPT_SAMPLES-2:0], pin_in};
			if (&st_nxt.hist && !st_r.level) begin
				st_nxt.level = 1'b1;
			end else if (~|st_nxt.hist && st_r.level) begin
				st_nxt.level = 1'b0;
				st_nxt.fall = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin_out.level = st_r.level;
	assign pin_out.fall = st_r.fall;

endmodule : evt16_pin_filter

`default_nettype wire

/* File: rtl/evt16_pkg.sv */
// Package of constants and carrier types for the 16-bit event counter
package evt16_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] EVT16_OFS_MODE = 8'h00;
	localparam logic [7:0] EVT16_OFS_COUNT = 8'h04;
	localparam logic [7:0] EVT16_OFS_CAPTURE = 8'h08;
	localparam logic [7:0] EVT16_OFS_CMP_A = 8'h0C;
	localparam logic [7:0] EVT16_OFS_CMP_B = 8'h10;
	localparam logic [7:0] EVT16_OFS_STATUS = 8'h14;

	// ==========================================================
	// Field positions in the mode register
	localparam int EVT16_SRC_LSB = 0;
	localparam int EVT16_CLR_LSB = 2;

	// Field positions in the status register
	localparam int EVT16_ST_OVF = 0;
	localparam int EVT16_ST_MATCH_A = 1;
	localparam int EVT16_ST_MATCH_B = 2;
	localparam int EVT16_ST_EDGE = 3;

	// ==========================================================
	// Values after reset, counter limit and bus response codes
	localparam logic [3:0] EVT16_MODE_RST = 4'h0;
	localparam logic [15:0] EVT16_CNT_RST = 16'h0000;
	localparam logic [15:0] EVT16_CNT_MAX = 16'hFFFF;
	localparam logic [1:0] EVT16_RESP_OKAY = 2'h0;
	localparam logic [1:0] EVT16_RESP_SLVERR = 2'h2;

	// Source select codes
	localparam logic [1:0] EVT16_SRC_TICK = 2'h0;
	localparam logic [1:0] EVT16_SRC_TICK_GATED = 2'h1;
	localparam logic [1:0] EVT16_SRC_PIN = 2'h2;
	localparam logic [1:0] EVT16_SRC_PIN_GATED = 2'h3;

	// Clear mode codes
	localparam logic [1:0] EVT16_CLR_HOLD = 2'h0;
	localparam logic [1:0] EVT16_CLR_FREE = 2'h1;
	localparam logic [1:0] EVT16_CLR_EDGE = 2'h2;
	localparam logic [1:0] EVT16_CLR_MATCH_B = 2'h3;

	// ==========================================================
	// Timing: pin sample period and counter tick ratio
	localparam int EVT16_CLK_NS = 100;
	localparam int EVT16_SAMPLE_NS = 250;
	localparam int EVT16_SAMPLE_CYC =
		(EVT16_SAMPLE_NS + EVT16_CLK_NS - 1) / EVT16_CLK_NS;
	localparam int EVT16_TICK_RATIO = 4;
	localparam int EVT16_ACCEPT_SAMPLES = 2;

	// ==========================================================
	// Filtered pin carrier
	typedef struct packed {
		logic level;
		logic fall;
	} evt16_pin_t;

endpackage : evt16_pkg

/* File: sim/evt16_counter_props.sv */
// Checker of event and bus timing at the event counter ports
`timescale 1ns/1ns
`default_nettype none

module evt16_counter_props
	import evt16_pkg::*;
#(
	parameter int SAMPLE_CYC = EVT16_SAMPLE_CYC,
	parameter int TICK_RATIO = EVT16_TICK_RATIO
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pins and events
	input wire logic count_pin,
	input wire logic square_out,
	input wire logic hw_stop,
	input wire logic match_a,
	input wire logic match_b,
	input wire logic irq_match_a,
	input wire logic irq_match_b,
	input wire logic irq_edge,
	// Bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	// ==========================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_irq_a_tie: assert property (match_a == irq_match_a)
		else $error("irq a differs from match a");
	a_irq_b_tie: assert property (match_b == irq_match_b)
		else $error("irq b differs from match b");
	a_match_one_cycle: assert property (match_a || match_b |=> !match_a && !match_b)
		else $error("match longer than one cycle");
	a_edge_one_cycle: assert property (irq_edge |=> !irq_edge)
		else $error("edge pulse longer than one cycle");
	a_edge_filtered: assert property (irq_edge |-> !$past(count_pin, 3) || !$past(square_out, 3))
		else $error("edge without a settled low level");
	a_stop_quiet: assert property (hw_stop ##1 hw_stop |=> !match_a && !match_b)
		else $error("match while stopped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while pending");

	// Main scenarios
	c_match_a: cover property (match_a);
	c_match_b: cover property (match_b);
	c_edge: cover property (irq_edge);
endmodule : evt16_counter_props

bind evt16_counter evt16_counter_props
	#(.SAMPLE_CYC(SAMPLE_CYC), .TICK_RATIO(TICK_RATIO)) u_props (
	.aclk(aclk), .aresetn(aresetn), .count_pin(count_pin), .square_out(square_out),
	.hw_stop(hw_stop), .match_a(match_a), .match_b(match_b), .irq_match_a(irq_match_a),
	.irq_match_b(irq_match_b), .irq_edge(irq_edge), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

/* File: sim/evt16_pin_model.sv */
// Far-side model driving the count pin and the square-wave output
`timescale 1ns/1ns
`default_nettype none

module evt16_pin_model (
	// Clock
	input wire logic aclk,
	// Low pulse requests and their length in cycles
	input wire logic cp_req,
	input wire logic sq_req,
	input wire logic [7:0] len,
	// Pins seen by the counter
	output logic count_pin,
	output logic square_out
);
	// ==========================================================
	// Pulse timers
	int cp_left;
	int sq_left;

	// Each pin idles high and drops for the requested length
	always_ff @(posedge aclk) begin
		cp_left <= cp_req ? int'(len) : (cp_left > 0 ? cp_left - 1 : 0);
		sq_left <= sq_req ? int'(len) : (sq_left > 0 ? sq_left - 1 : 0);
	end

	// Pin levels from the timers
	assign count_pin = (cp_left == 0);
	assign square_out = (sq_left == 0);
endmodule : evt16_pin_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench of the event counter over its bus and pins
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin num_errors++; $display("unexpected %s exp %h seen %h", n, e, s); end end

module tb;
	import evt16_pkg::*;
	// ==========================================================
	// Signals and model state
	logic aclk, aresetn, hw_stop, cp_req, sq_req, count_pin, square_out;
	logic match_a, match_b, irq_match_a, irq_match_b, irq_edge, overflow_flag;
	logic [7:0] len, s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int num_errors, n_tests, m_cnt, n, n_edge, n_mb;

	evt16_counter #(.SAMPLE_CYC(3), .TICK_RATIO(4)) dut (
		.aclk(aclk), .aresetn(aresetn), .count_pin(count_pin), .square_out(square_out),
		.hw_stop(hw_stop), .match_a(match_a), .match_b(match_b), .irq_match_a(irq_match_a),
		.irq_match_b(irq_match_b), .irq_edge(irq_edge), .overflow_flag(overflow_flag),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);
	evt16_pin_model u_pins (
		.aclk(aclk), .cp_req(cp_req), .sq_req(sq_req), .len(len),
		.count_pin(count_pin), .square_out(square_out)
	);

	// Clock of 100 ns
	initial begin
		aclk = 0;
		forever #50 aclk = ~aclk;
	end

	// Pulse counters for event outputs, read mid-cycle
	always @(negedge aclk) begin
		if (irq_edge === 1'b1) n_edge++;
		if (match_b === 1'b1) n_mb++;
	end

	// ==========================================================
	// Tasks
	task automatic conclude;
		$display("errors %0d comparisons %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : conclude

	task automatic tmo;
		num_errors++;
		conclude();
	endtask : tmo

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int i;
		bit aw, w;
		aw = 0;
		w = 0;
		i = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (!(aw && w)) begin
			@(negedge aclk);
			aw |= s_axi_awvalid & s_axi_awready;
			w |= s_axi_wvalid & s_axi_wready;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 0;
			if (w) s_axi_wvalid <= 0;
			if (++i > 50) tmo();
		end
		s_axi_bready <= 1;
		do begin @(negedge aclk); if (++i > 100) tmo(); end while (s_axi_bvalid !== 1'b1);
		`CHK("bresp", e, s_axi_bresp)
		@(posedge aclk);
		s_axi_bready <= 0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int i;
		i = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin @(negedge aclk); if (++i > 50) tmo(); end while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 0;
		do begin @(negedge aclk); if (++i > 100) tmo(); end while (s_axi_rvalid !== 1'b1);
		rd_v = s_axi_rdata;
		rd_r = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 0;
	endtask : rd

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		rd(a);
		`CHK("rdata", e, rd_v)
		`CHK("rresp", r, rd_r)
	endtask : chk_rd

	// Low pulse of w cycles on one pin, then a settling gap
	task automatic pulse(input bit sq, input int w);
		@(posedge aclk);
		cp_req <= !sq;
		sq_req <= sq;
		len <= w[7:0];
		@(posedge aclk);
		cp_req <= 0;
		sq_req <= 0;
		repeat (w + 12) @(posedge aclk);
	endtask : pulse

	// ==========================================================
	// Main sequence
	initial begin
		{aresetn, hw_stop, cp_req, sq_req, len, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		void'($urandom(32'hf011));
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		chk_rd(EVT16_OFS_MODE, 0, EVT16_RESP_OKAY);
		chk_rd(EVT16_OFS_COUNT, 0, EVT16_RESP_OKAY);
		chk_rd(EVT16_OFS_CAPTURE, 0, EVT16_RESP_OKAY);
		chk_rd(EVT16_OFS_CMP_A, 0, EVT16_RESP_OKAY);
		chk_rd(8'h3C, 0, EVT16_RESP_SLVERR);
		wr(8'h3C, 1, EVT16_RESP_SLVERR);
		for (int m = 0; m < 16; m++) begin
			wr(EVT16_OFS_MODE, m, EVT16_RESP_OKAY);
			chk_rd(EVT16_OFS_MODE, m, EVT16_RESP_OKAY);
		end
		// Pin counting with rejected glitches, square fall captures
		wr(EVT16_OFS_MODE, 0, EVT16_RESP_OKAY);
		wr(EVT16_OFS_MODE, 6, EVT16_RESP_OKAY);
		n = 3 + $urandom % 6;
		for (int k = 0; k < n; k++) begin
			pulse(0, 8);
			pulse(0, 2);
		end
		m_cnt = n;
		chk_rd(EVT16_OFS_COUNT, m_cnt, EVT16_RESP_OKAY);
		pulse(1, 8);
		chk_rd(EVT16_OFS_CAPTURE, m_cnt, EVT16_RESP_OKAY);
		// Edge clear by square fall, capture first
		wr(EVT16_OFS_MODE, 0, EVT16_RESP_OKAY);
		wr(EVT16_OFS_MODE, 32'hA, EVT16_RESP_OKAY);
		wr(EVT16_OFS_STATUS, 32'hF, EVT16_RESP_OKAY);
		for (int k = 0; k < n + 1; k++) pulse(0, 8);
		pulse(1, 8);
		chk_rd(EVT16_OFS_CAPTURE, n + 1, EVT16_RESP_OKAY);
		chk_rd(EVT16_OFS_COUNT, 0, EVT16_RESP_OKAY);
		chk_rd(EVT16_OFS_STATUS, 32'h8, EVT16_RESP_OKAY);
		// Tick counting with both matches, cleared at B
		wr(EVT16_OFS_CMP_A, 1 + $urandom % 2, EVT16_RESP_OKAY);
		wr(EVT16_OFS_CMP_B, 3, EVT16_RESP_OKAY);
		wr(EVT16_OFS_MODE, 0, EVT16_RESP_OKAY);
		wr(EVT16_OFS_STATUS, 32'hF, EVT16_RESP_OKAY);
		wr(EVT16_OFS_MODE, 32'hC, EVT16_RESP_OKAY);
		repeat (150) @(posedge aclk);
		chk_rd(EVT16_OFS_STATUS, 32'h6, EVT16_RESP_OKAY);
		chk_rd(EVT16_OFS_CMP_B, 0, EVT16_RESP_OKAY);
		rd(EVT16_OFS_COUNT);
		`CHK("count bound", 1'b1, rd_v <= 3)
		// Gated tick stalls while the pin is low
		wr(EVT16_OFS_MODE, 0, EVT16_RESP_OKAY);
		@(posedge aclk);
		cp_req <= 1;
		len <= 8'd250;
		@(posedge aclk);
		cp_req <= 0;
		repeat (20) @(posedge aclk);
		wr(EVT16_OFS_MODE, 5, EVT16_RESP_OKAY);
		repeat (150) @(posedge aclk);
		chk_rd(EVT16_OFS_COUNT, 0, EVT16_RESP_OKAY);
		chk_rd(EVT16_OFS_CAPTURE, 0, EVT16_RESP_OKAY);
		// Hardware stop clears the mode, counter then held
		wr(EVT16_OFS_MODE, 6, EVT16_RESP_OKAY);
		hw_stop <= 1;
		repeat (3) @(posedge aclk);
		hw_stop <= 0;
		chk_rd(EVT16_OFS_MODE, 0, EVT16_RESP_OKAY);
		repeat (100) @(posedge aclk);
		chk_rd(EVT16_OFS_COUNT, 0, EVT16_RESP_OKAY);
		`CHK("edges", 3, n_edge)
		`CHK("match b", 3, n_mb)
		`CHK("overflow", 1'b0, overflow_flag)
		conclude();
	end
endmodule : tb
`default_nettype wire
